// *** dpw_dev_model.sv ***
// Behavioural model of the DAC parallel port.
`timescale 1ns/1ps
module dpw_dev_model #(parameter int W = 12) (
    input wire logic sel_b_i,
    input wire logic rd_wr_i,
    input wire logic [W-1:0] hd_i,
    input wire logic [W-1:0] hoe_b_i,
    output logic [W-1:0] line_o
);
    logic [W-1:0] dac_q = '0;
    logic [W-1:0] last_q = '0;
    logic [W-1:0] drv;
    logic [W-1:0] val;
    // Released bits flip to the inverse of their last level, so a stale
    // read is caught instead of hidden.
    assign drv = ~hoe_b_i | {W{!sel_b_i && rd_wr_i}};
    assign val = (~hoe_b_i & hd_i) | (hoe_b_i & dac_q);
    assign line_o = (drv & val) | (~drv & ~last_q);
    always @(drv or val) last_q = (drv & val) | (~drv & last_q);
    always @(posedge sel_b_i) if (!rd_wr_i) dac_q <= line_o;
endmodule

// *** dpw_host.sv ***
// Host controller that writes and reads back a parallel-port DAC.
`timescale 1ns/1ps
// Behaviour
// - Data word is 8, 10 or 12 bits, set by parameter DATA_W.
// - Write: select low with read/write low; data lines driven by host.
// - Every write gets a full falling then rising select edge.
// - Read: read/write held high while select is driven low.
// - Host inserts one wait cycle per write and three per read for port timing.
module dpw_host #(
    parameter int DATA_W = dpw_pkg::DATA_W_DEF
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire logic req_rd_i,
    input wire logic [DATA_W-1:0] req_data_i,
    output logic busy_o,
    output logic done_o,
    output logic [DATA_W-1:0] rd_data_o,
    output logic sel_b_o,
    output logic rd_wr_o,
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] data_o,
    output logic [DATA_W-1:0] data_oe_b_o
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // Only the three converter variants have a matching data lane count.
    if (DATA_W != 8 && DATA_W != 10 && DATA_W != 12) begin
        $error("DATA_W must be 8, 10 or 12");
    end

    localparam logic [dpw_pkg::CNT_W-1:0] LOW_N =
        dpw_pkg::CNT_W'(dpw_pkg::SEL_LOW_CYC);
    localparam logic [dpw_pkg::CNT_W-1:0] HIGH_N =
        dpw_pkg::CNT_W'(dpw_pkg::SEL_HIGH_CYC);
    localparam logic [dpw_pkg::CNT_W-1:0] WAIT_N =
        dpw_pkg::CNT_W'(dpw_pkg::WAIT_CYC);
    // Reads stretch the wait so the synchronised lines are settled.
    localparam logic [dpw_pkg::CNT_W-1:0] RD_EXTRA_N =
        dpw_pkg::CNT_W'(dpw_pkg::SYNC_CYC);
    localparam logic [dpw_pkg::CNT_W-1:0] ONE_N =
        dpw_pkg::CNT_W'(1);

    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    // The device drives the read data asynchronously, so it is resynced
    // before capture; the wait state covers the extra two cycles.
    logic [DATA_W-1:0] din_meta_q;
    logic [DATA_W-1:0] din_sync_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            din_meta_q <= '0;
            din_sync_q <= '0;
        end else begin
            din_meta_q <= data_i;
            din_sync_q <= din_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    dpw_pkg::dpw_state_t state_q;
    logic [dpw_pkg::CNT_W-1:0] cnt_q;
    dpw_pkg::dpw_ctl_t ctl_q;
    logic rd_q;
    logic done_q;
    logic [DATA_W-1:0] dout_q;
    logic [DATA_W-1:0] oe_b_q;
    logic [DATA_W-1:0] rdat_q;
    logic busy_q;
    logic take_w;
    logic last_w;

    assign take_w = (state_q == dpw_pkg::DPW_IDLE) && req_i;
    assign last_w = (cnt_q <= ONE_N);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= dpw_pkg::DPW_IDLE;
        end else begin
            case (state_q)
                dpw_pkg::DPW_IDLE: begin
                    if (take_w) begin
                        state_q <= dpw_pkg::DPW_LOW;
                    end
                end
                dpw_pkg::DPW_LOW: begin
                    if (last_w) begin
                        state_q <= dpw_pkg::DPW_WAIT;
                    end
                end
                dpw_pkg::DPW_WAIT: begin
                    if (last_w) begin
                        state_q <= dpw_pkg::DPW_HIGH;
                    end
                end
                dpw_pkg::DPW_HIGH: begin
                    if (last_w) begin
                        state_q <= dpw_pkg::DPW_IDLE;
                    end
                end
                default: begin
                    state_q <= dpw_pkg::DPW_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Phase counter
    // ------------------------------------------------------------
    // Each phase loads its full length and counts down to one, so a
    // phase of N cycles spends exactly N edges in its state.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= '0;
            rd_q <= 1'b0;
        end else begin
            case (state_q)
                dpw_pkg::DPW_IDLE: begin
                    if (take_w) begin
                        rd_q <= req_rd_i;
                        cnt_q <= LOW_N;
                    end
                end
                dpw_pkg::DPW_LOW: begin
                    if (last_w) begin
                        cnt_q <= WAIT_N + (rd_q ? RD_EXTRA_N : '0);
                    end else begin
                        cnt_q <= cnt_q - ONE_N;
                    end
                end
                dpw_pkg::DPW_WAIT: begin
                    if (last_w) begin
                        cnt_q <= HIGH_N;
                    end else begin
                        cnt_q <= cnt_q - ONE_N;
                    end
                end
                dpw_pkg::DPW_HIGH: begin
                    if (!last_w) begin
                        cnt_q <= cnt_q - ONE_N;
                    end
                end
                default: begin
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Busy flag
    // ------------------------------------------------------------
    // Kept as its own flop, mirroring the state, so busy_o is glitch free.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_q <= 1'b0;
        end else if (take_w) begin
            busy_q <= 1'b1;
        end else if (state_q == dpw_pkg::DPW_HIGH && last_w) begin
            busy_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctl_q <= '{sel_b: 1'b1, rd_wr: 1'b1};
            dout_q <= '0;
            oe_b_q <= '1;
        end else if (state_q == dpw_pkg::DPW_IDLE && req_i) begin
            ctl_q <= '{sel_b: 1'b0, rd_wr: req_rd_i};
            dout_q <= req_data_i;
            oe_b_q <= req_rd_i ? '1 : '0;
        end else if (state_q == dpw_pkg::DPW_WAIT && cnt_q <= 8'h01) begin
            // Data stays driven past the rising select edge for hold.
            ctl_q.sel_b <= 1'b1;
        end else if (state_q == dpw_pkg::DPW_HIGH && cnt_q <= 8'h01) begin
            ctl_q.rd_wr <= 1'b1;
            oe_b_q <= '1;
        end
    end

    // ------------------------------------------------------------
    // Completion and read data
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_q <= 1'b0;
            rdat_q <= '0;
        end else begin
            done_q <= (state_q == dpw_pkg::DPW_HIGH) && (cnt_q <= 8'h01);
            if (state_q == dpw_pkg::DPW_WAIT && cnt_q <= 8'h01 && rd_q) begin
                rdat_q <= din_sync_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output is a flop so the pins carry no decode glitches.
    assign busy_o = busy_q;
    assign done_o = done_q;
    assign rd_data_o = rdat_q;
    assign sel_b_o = ctl_q.sel_b;
    assign rd_wr_o = ctl_q.rd_wr;
    assign data_o = dout_q;
    assign data_oe_b_o = oe_b_q;

endmodule

// *** dpw_host_checker.sv ***
// Timing checks on the host port of the DAC controller.
`timescale 1ns/1ps
module dpw_host_checker #(parameter int DATA_W = 12) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire logic req_rd_i,
    input wire logic [DATA_W-1:0] req_data_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic [DATA_W-1:0] rd_data_o,
    input wire logic sel_b_o,
    input wire logic rd_wr_o,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic [DATA_W-1:0] data_o,
    input wire logic [DATA_W-1:0] data_oe_b_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence take_wr;
        req_i && !busy_o && !req_rd_i;
    endsequence
    sequence take_rd;
        req_i && !busy_o && req_rd_i;
    endsequence
    wr_start_a: assert property (take_wr |=> !sel_b_o && !rd_wr_o
        && data_oe_b_o == '0 && data_o == $past(req_data_i))
        else $error("write start wrong");
    sel_width_a: assert property (take_wr |=>
        (!sel_b_o)[*4] ##[1:2] sel_b_o) else $error("select pulse wrong");
    wr_done_a: assert property (take_wr |-> ##8 done_o)
        else $error("write done late");
    rd_done_a: assert property (take_rd |-> ##10 done_o)
        else $error("read done late");
    rd_release_a: assert property (take_rd |=>
        (!sel_b_o && rd_wr_o && data_oe_b_o == '1)[*4])
        else $error("read phase wrong");
    no_fight_a: assert property (data_oe_b_o != '1 |-> !rd_wr_o)
        else $error("drive during read");
    rd_load_a: assert property ($changed(rd_data_o) |-> busy_o && rd_wr_o)
        else $error("read data moved");
    idle_sel_a: assert property (!busy_o |-> sel_b_o && rd_wr_o)
        else $error("select not idle");
endmodule
bind dpw_host dpw_host_checker #(.DATA_W(DATA_W)) dpw_host_checker_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .req_rd_i(req_rd_i),
    .req_data_i(req_data_i), .busy_o(busy_o), .done_o(done_o),
    .rd_data_o(rd_data_o), .sel_b_o(sel_b_o), .rd_wr_o(rd_wr_o),
    .data_i(data_i), .data_o(data_o), .data_oe_b_o(data_oe_b_o));

// *** dpw_host_tb.sv ***
// Self-checking bench for the DAC parallel port host.
`timescale 1ns/1ps
module dpw_host_tb;
    logic clk_i = 0, rst_b_i = 0, req_i = 0, req_rd_i = 0;
    logic [11:0] req_data_i = '0, exp_q = '0;
    logic busy_o, done_o, sel_b_o, rd_wr_o;
    logic [11:0] rd_data_o, data_i, data_o, data_oe_b_o;
    logic [31:0] rb;
    int err_total = 0, cmp_count = 0, seed = 92;
    logic hung = 1'b0;
    always #2.5 clk_i = ~clk_i;
    dpw_host dpw_host_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i),
        .req_rd_i(req_rd_i), .req_data_i(req_data_i), .busy_o(busy_o),
        .done_o(done_o), .rd_data_o(rd_data_o), .sel_b_o(sel_b_o),
        .rd_wr_o(rd_wr_o), .data_i(data_i), .data_o(data_o),
        .data_oe_b_o(data_oe_b_o));
    dpw_dev_model dpw_dev_model_inst (.sel_b_i(sel_b_o), .rd_wr_i(rd_wr_o),
        .hd_i(data_o), .hoe_b_i(data_oe_b_o), .line_o(data_i));
    task chk(input string n, input logic [11:0] e, input logic [11:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task give_verdict;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // A read expects the last word written, so a lost write shows here.
    task acc(input logic rd, input logic [11:0] d);
        int i;
        if (hung) return;
        @(posedge clk_i);
        req_i <= 1'b1;
        req_rd_i <= rd;
        req_data_i <= d;
        @(posedge clk_i);
        req_i <= 1'b0;
        #1;
        for (i = 0; i < 20 && done_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        if (i == 20) begin
            err_total++;
            hung = 1'b1;
            $display("BAD done_o exp 1 got %b", done_o);
        end else if (rd) chk("rd_data", exp_q, rd_data_o);
        else exp_q = d;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        acc(1'b1, 12'h000);
        acc(1'b0, 12'hFFF);
        acc(1'b1, 12'h000);
        acc(1'b0, 12'h000);
        acc(1'b1, 12'h000);
        acc(1'b0, 12'hA5A);
        acc(1'b0, 12'h5A5);
        acc(1'b1, 12'h000);
        repeat (60) begin
            rb = $random(seed);
            acc(rb[12], rb[11:0]);
        end
        acc(1'b1, 12'h000);
        give_verdict();
    end
endmodule

// *** dpw_pkg.sv ***
// Package of constants and carrier types for the DAC parallel port host.
package dpw_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SEL_LOW_NS = 17;
    localparam int SEL_LOW_CYC =
        (SEL_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SEL_HIGH_NS = 10;
    localparam int SEL_HIGH_CYC =
        (SEL_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WAIT_CYC = 1;
    localparam int SYNC_CYC = 2;
    localparam int DATA_W_DEF = 12;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DPW_IDLE,
        DPW_LOW,
        DPW_WAIT,
        DPW_HIGH
    } dpw_state_t;

    typedef struct packed {
        logic sel_b;
        logic rd_wr;
    } dpw_ctl_t;

endpackage
